/* File: hdl/prbc_cfg.svh */
// register offsets, field positions, reset values and timing counts
// assumes byte addresses on a 32-bit Avalon-MM slave port
`ifndef PRBC_CFG_SVH
`define PRBC_CFG_SVH

// register byte offsets
`define OFS_RST_MAIN   9'h00c
`define OFS_RST_SC     9'h010
`define OFS_DET_CTRL   9'h018
`define OFS_INT_STAT   9'h020
`define OFS_INT_MASK   9'h024
`define OFS_UNLOCK     9'h100

// unlock key bytes, written in this order
`define UNLOCK_KEY0    8'h59
`define UNLOCK_KEY1    8'h16
`define UNLOCK_KEY2    8'h88

// peripheral_reset_ctrl_main bit positions
`define GPIO_RST_BIT   1
`define TMR_RST_LSB    2
`define TMR_RST_MSB    5
`define I2C_RST_LSB    8
`define I2C_RST_MSB    9
`define SPI_RST_LSB    12
`define SPI_RST_MSB    15
`define UART_RST_LSB   16
`define UART_RST_MSB   18
`define PWM_LO_BIT     20
`define PWM_HI_BIT     21
`define CMP_RST_BIT    22
`define KBD_RST_BIT    23
`define CAN_RST_LSB    24
`define CAN_RST_MSB    25
`define USBDEV_BIT     27
`define ADCONV_BIT     28
`define AUDIO_BIT      29

// peripheral_reset_ctrl_smartcard width
`define SC_RST_W       3

// brownout_detector_ctrl bit positions
`define DET_ENABLE_BIT 0
`define DET_THR_LSB    1
`define DET_THR_MSB    2
`define DET_RSTSEL_BIT 3
`define DET_FLAG_BIT   4
`define DET_LPM_BIT    5
`define DET_OUT_BIT    6
`define LVRST_EN_BIT   7

// flash_user_config_word field positions
`define CFG_RSTSEL_BIT 20
`define CFG_THR_LSB    21
`define CFG_THR_MSB    22
`define CFG_ENABLE_BIT 23

// interrupt status and mask bits
`define INT_CROSS_BIT  0
`define INT_LEVEL_BIT  1

// reset values
`define RST_MAIN_INIT  32'h0000_0000
`define RST_SC_INIT    3'h0
`define LVRST_INIT     1'b1

// timing
`define CLK_PERIOD_NS  100
`define LVR_SETTLE_NS  100000
`define LVR_SETTLE_CYC ((`LVR_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: hdl/prbc_pkg.sv */
// types shared by the reset and brown-out control slice
// assumes nothing of its surroundings
package prbc_pkg;
    typedef logic [1:0] thr_t;

    typedef enum logic [1:0] {
        LOCKED   = 2'b00,
        GOT_KEY0 = 2'b01,
        GOT_KEY1 = 2'b10,
        UNLOCKED = 2'b11
    } lock_e;
endpackage

/* File: hdl/periph_reset_and_brownout_ctrl.sv */
// peripheral reset bits and brown-out detector control with unlock gate
// assumes a 10 MHz clk_sys, an Avalon-MM master and an analog detector
// whose trip output arrives asynchronously on detectorRaw
//
// How it works
// - writing 1 asserts that peripheral's reset
// - reset holds until software writes 0
// - bits 16-18 uart, 12-15 spi, 8-9 i2c
// - bits 2-5 timers, bit 1 gpio
// - 24-25 can, 27 usb, 28 adc, 29 i2s
// - 20/21 pwm groups, 22 comparator, 23 ps2
// - smartcard bits 0-2, rest reserved
// - protected bits need 59h,16h,88h unlock first
// - lvr enable defaults on, active after 100us
// - output bit high only below threshold, enabled
// - bit 5 selects detector low power
// - crossing either way sets flag, requests interrupt
// - writing 1 clears crossing flag
// - reset-select plus enable gives chip reset
// - interrupt mode holds until enable cleared
// - two-bit threshold select, four trip levels
// - bit 0 enables the detector
// - enable, threshold, reset-select load from config
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "prbc_cfg.svh"

module periph_reset_and_brownout_ctrl (
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic [8:0]   address,
    input  wire logic         read,
    input  wire logic         write,
    input  wire logic [31:0]  writedata,
    input  wire logic [3:0]   byteenable,
    output logic [31:0]       readdata,
    output logic              waitrequest,
    input  wire logic [31:0]  flashUserConfigWord,
    input  wire logic         detectorRaw,
    output logic [31:0]       periphRstMain,
    output logic [2:0]        periphRstSmartcard,
    output logic              detectorEnable,
    output prbc_pkg::thr_t    detectorThresholdSel,
    output logic              detectorLowPowerSel,
    output logic              lowVoltageResetEnable,
    output logic              lowVoltageResetActive,
    output logic              chipResetReq,
    output logic              irq
);
    import prbc_pkg::*;

    localparam logic [9:0] LVR_CYC = 10'(`LVR_SETTLE_CYC);

    // implemented bits of the main reset register
    localparam logic [31:0] MAIN_MASK =
        (32'h1 << `GPIO_RST_BIT) |
        (32'h0000_000f << `TMR_RST_LSB) |
        (32'h0000_0003 << `I2C_RST_LSB) |
        (32'h0000_000f << `SPI_RST_LSB) |
        (32'h0000_0007 << `UART_RST_LSB) |
        (32'h1 << `PWM_LO_BIT) |
        (32'h1 << `PWM_HI_BIT) |
        (32'h1 << `CMP_RST_BIT) |
        (32'h1 << `KBD_RST_BIT) |
        (32'h0000_0003 << `CAN_RST_LSB) |
        (32'h1 << `USBDEV_BIT) |
        (32'h1 << `ADCONV_BIT) |
        (32'h1 << `AUDIO_BIT);

    // bus handshake state
    logic        ackFf;
    logic        nxt_ack;
    logic [31:0] rdataFf;
    logic [31:0] nxt_rdata;

    // unlock sequence
    lock_e lockFf;
    lock_e nxt_lock;

    // software registers
    logic [31:0] rstMainFf;
    logic [31:0] nxt_rstMain;
    logic [2:0]  rstScFf;
    logic [2:0]  nxt_rstSc;
    logic        detEnFf;
    logic        nxt_detEn;
    thr_t        thrFf;
    thr_t        nxt_thr;
    logic        rstSelFf;
    logic        nxt_rstSel;
    logic        lpmFf;
    logic        nxt_lpm;
    logic        lvrEnFf;
    logic        nxt_lvrEn;
    logic        flagFf;
    logic        nxt_flag;
    logic [1:0]  intStatFf;
    logic [1:0]  nxt_intStat;
    logic [1:0]  intMaskFf;
    logic [1:0]  nxt_intMask;
    logic        cfgDoneFf;
    logic        nxt_cfgDone;

    // detector synchroniser
    logic        detMetaFf;
    logic        detSyncFf;
    logic        detPrevFf;

    // settling counter
    logic [9:0]  lvrCntFf;
    logic [9:0]  nxt_lvrCnt;

    // decoded access terms
    logic        wrEn;
    logic [31:0] wMask;
    logic [31:0] wVal;
    logic        selMain;
    logic        selSc;
    logic        selDet;
    logic        selStat;
    logic        selMask;
    logic        selLock;
    logic        unlocked;
    logic        detOut;
    logic        crossing;
    logic        levelIrq;
    logic [7:0]  detWord;

    // register address decode
    always_comb begin
        selMain  = (address == `OFS_RST_MAIN);
        selSc    = (address == `OFS_RST_SC);
        selDet   = (address == `OFS_DET_CTRL);
        selStat  = (address == `OFS_INT_STAT);
        selMask  = (address == `OFS_INT_MASK);
        selLock  = (address == `OFS_UNLOCK);
    end

    // byte lanes, commit strobe and lock state
    always_comb begin
        wrEn     = write & ackFf;
        wMask    = {{8{byteenable[3]}}, {8{byteenable[2]}},
                    {8{byteenable[1]}}, {8{byteenable[0]}}};
        wVal     = writedata & wMask;
        unlocked = (lockFf == UNLOCKED);
    end

    // detector status terms
    always_comb begin
        detOut   = detEnFf & detSyncFf;
        crossing = detEnFf & (detSyncFf != detPrevFf);
        levelIrq = detEnFf & ~rstSelFf & detOut;
        detWord  = {lvrEnFf, detOut, lpmFf, flagFf,
                    rstSelFf, thrFf, detEnFf};
    end

    // one wait state, then the answer stands for one cycle
    always_comb begin
        nxt_ack   = (read | write) & ~ackFf;
        nxt_rdata = rdataFf;
        if (read & ~ackFf) begin
            nxt_rdata = 32'h0;
            unique case (1'b1)
                selMain: nxt_rdata = rstMainFf;
                selSc:   nxt_rdata = {29'h0, rstScFf};
                selDet:  nxt_rdata = {24'h0, detWord};
                selStat: nxt_rdata = {30'h0, intStatFf};
                selMask: nxt_rdata = {30'h0, intMaskFf};
                selLock: nxt_rdata = {31'h0, unlocked};
                default: nxt_rdata = 32'h0;
            endcase
        end
    end

    // handshake and read data registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ackFf   <= 1'b0;
            rdataFf <= 32'h0;
        end else begin
            ackFf   <= nxt_ack;
            rdataFf <= nxt_rdata;
        end
    end

    // unlock sequence: any wrong byte or write while open relocks
    always_comb begin
        nxt_lock = lockFf;
        if (wrEn && selLock && byteenable[0]) begin
            unique case (lockFf)
                LOCKED:
                    nxt_lock = (writedata[7:0] == `UNLOCK_KEY0) ? GOT_KEY0 : LOCKED;
                GOT_KEY0:
                    nxt_lock = (writedata[7:0] == `UNLOCK_KEY1) ? GOT_KEY1 : LOCKED;
                GOT_KEY1:
                    nxt_lock = (writedata[7:0] == `UNLOCK_KEY2) ? UNLOCKED : LOCKED;
                UNLOCKED:
                    nxt_lock = LOCKED;
            endcase
        end
    end

    // lock state register, locked out of reset
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lockFf <= LOCKED;
        end else begin
            lockFf <= nxt_lock;
        end
    end

    // peripheral reset bits follow software writes only
    always_comb begin
        nxt_rstMain = rstMainFf;
        nxt_rstSc   = rstScFf;
        if (wrEn && selMain) begin
            nxt_rstMain = ((rstMainFf & ~wMask) | wVal) & MAIN_MASK;
        end
        if (wrEn && selSc && byteenable[0]) begin
            nxt_rstSc = writedata[`SC_RST_W-1:0];
        end
    end

    // reset bits hold their level until rewritten
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rstMainFf <= `RST_MAIN_INIT;
            rstScFf   <= `RST_SC_INIT;
        end else begin
            rstMainFf <= nxt_rstMain;
            rstScFf   <= nxt_rstSc;
        end
    end

    // detector control next values
    always_comb begin
        nxt_detEn   = detEnFf;
        nxt_thr     = thrFf;
        nxt_rstSel  = rstSelFf;
        nxt_lpm     = lpmFf;
        nxt_lvrEn   = lvrEnFf;
        nxt_flag    = flagFf;
        nxt_cfgDone = 1'b1;

        // protected detector fields
        if (wrEn && selDet && byteenable[0] && unlocked) begin
            nxt_detEn  = writedata[`DET_ENABLE_BIT];
            nxt_thr    = writedata[`DET_THR_MSB:`DET_THR_LSB];
            nxt_rstSel = writedata[`DET_RSTSEL_BIT];
            nxt_lpm    = writedata[`DET_LPM_BIT];
            nxt_lvrEn  = writedata[`LVRST_EN_BIT];
        end

        // crossing flag: set wins over write-one clear
        if (wrEn && selDet && byteenable[0] && writedata[`DET_FLAG_BIT]) begin
            nxt_flag = 1'b0;
        end
        if (crossing) begin
            nxt_flag = 1'b1;
        end

        // defaults from the flash configuration, first edge after reset
        if (!cfgDoneFf) begin
            nxt_detEn  = flashUserConfigWord[`CFG_ENABLE_BIT];
            nxt_thr    = flashUserConfigWord[`CFG_THR_MSB:`CFG_THR_LSB];
            nxt_rstSel = flashUserConfigWord[`CFG_RSTSEL_BIT];
        end
    end

    // detector control registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            detEnFf   <= 1'b0;
            thrFf     <= 2'h0;
            rstSelFf  <= 1'b0;
            lpmFf     <= 1'b0;
            lvrEnFf   <= `LVRST_INIT;
            flagFf    <= 1'b0;
            cfgDoneFf <= 1'b0;
        end else begin
            detEnFf   <= nxt_detEn;
            thrFf     <= nxt_thr;
            rstSelFf  <= nxt_rstSel;
            lpmFf     <= nxt_lpm;
            lvrEnFf   <= nxt_lvrEn;
            flagFf    <= nxt_flag;
            cfgDoneFf <= nxt_cfgDone;
        end
    end

    // interrupt status: write-one clear, then events set
    always_comb begin
        nxt_intStat = intStatFf;
        nxt_intMask = intMaskFf;
        if (wrEn && selStat && byteenable[0]) begin
            nxt_intStat = intStatFf & ~writedata[1:0];
        end
        if (!detEnFf) begin
            nxt_intStat[`INT_LEVEL_BIT] = 1'b0;
        end
        if (crossing) begin
            nxt_intStat[`INT_CROSS_BIT] = 1'b1;
        end
        if (levelIrq) begin
            nxt_intStat[`INT_LEVEL_BIT] = 1'b1;
        end
        if (wrEn && selMask && byteenable[0]) begin
            nxt_intMask = writedata[1:0];
        end
    end

    // interrupt status and mask registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            intStatFf <= 2'h0;
            intMaskFf <= 2'h0;
        end else begin
            intStatFf <= nxt_intStat;
            intMaskFf <= nxt_intMask;
        end
    end

    // two-flop synchroniser, third flop for edge compare
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            detMetaFf <= 1'b0;
            detSyncFf <= 1'b0;
            detPrevFf <= 1'b0;
        end else begin
            detMetaFf <= detectorRaw;
            detSyncFf <= detMetaFf;
            detPrevFf <= detSyncFf;
        end
    end

    // settling delay after the low-voltage reset is enabled
    always_comb begin
        nxt_lvrCnt = lvrCntFf;
        if (!lvrEnFf) begin
            nxt_lvrCnt = 10'h0;
        end else if (lvrCntFf != LVR_CYC) begin
            nxt_lvrCnt = lvrCntFf + 10'h1;
        end
    end

    // settling counter register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lvrCntFf <= 10'h0;
        end else begin
            lvrCntFf <= nxt_lvrCnt;
        end
    end

    // bus answer outputs
    always_comb begin
        readdata              = rdataFf;
        waitrequest           = (read | write) & ~ackFf;
    end

    // reset, detector and interrupt outputs
    always_comb begin
        periphRstMain         = rstMainFf;
        periphRstSmartcard    = rstScFf;
        detectorEnable        = detEnFf;
        detectorThresholdSel  = thrFf;
        detectorLowPowerSel   = lpmFf;
        lowVoltageResetEnable = lvrEnFf;
        lowVoltageResetActive = lvrEnFf & (lvrCntFf == LVR_CYC);
        chipResetReq          = detEnFf & rstSelFf & detOut;
        irq                   = |(intStatFf & intMaskFf);
    end
endmodule

/* File: test/prbc_chk_sva.sv */
// port assertions for the reset and brown-out control slice
// assumes binding into periph_reset_and_brownout_ctrl, one clock
`timescale 1ns/1ps
module prbc_chk_sva (
    input wire logic           clk_sys,
    input wire logic           rst,
    input wire logic [8:0]     address,
    input wire logic           read,
    input wire logic           write,
    input wire logic [31:0]    writedata,
    input wire logic [3:0]     byteenable,
    input wire logic [31:0]    readdata,
    input wire logic           waitrequest,
    input wire logic           detectorRaw,
    input wire logic [31:0]    periphRstMain,
    input wire logic [2:0]     periphRstSmartcard,
    input wire logic           detectorEnable,
    input wire prbc_pkg::thr_t detectorThresholdSel,
    input wire logic           detectorLowPowerSel,
    input wire logic           lowVoltageResetEnable,
    input wire logic           lowVoltageResetActive,
    input wire logic           chipResetReq
);
    import prbc_pkg::*;
    localparam logic [31:0] IMPL = 32'h3bf7_f33e;
    logic [11:0] onCnt_ff;
    logic [11:0] nxt_onCnt;
    logic        wrOk;
    // cycles the low-voltage reset enable has been high, saturating at fff and then held there even if the enable drops
    always_comb begin
        nxt_onCnt = lowVoltageResetEnable ? onCnt_ff + 12'h001 : 12'h000;
        if (onCnt_ff == 12'hfff) nxt_onCnt = onCnt_ff;
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) onCnt_ff <= 12'h000;
        else onCnt_ff <= nxt_onCnt;
    end
    assign wrOk = write && !waitrequest;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_reset_sticky:
    assert property ($changed(periphRstMain) |-> $past(wrOk && address == 9'h00c))
        else $error("peripheral reset moved without a write");
    a_main_write:
    assert property (wrOk && address == 9'h00c && byteenable == 4'hf
        |=> periphRstMain == ($past(writedata) & IMPL)) else $error("main reset bits wrong");
    a_sc_write:
    assert property (wrOk && address == 9'h010 && byteenable[0]
        |=> periphRstSmartcard == $past(writedata[2:0])) else $error("card reset bits wrong");
    a_prot_writes:
    assert property ($changed({detectorEnable, detectorThresholdSel, detectorLowPowerSel,
        lowVoltageResetEnable}) && !$past(rst, 2) |-> $past(wrOk && address == 9'h018))
        else $error("protected bit moved without a write");
    a_chip_req:
    assert property (chipResetReq |-> detectorEnable && $past(detectorRaw, 2))
        else $error("chip reset without enabled trip");
    a_lvr_settle:
    assert property (lowVoltageResetActive |-> lowVoltageResetEnable && onCnt_ff >= 12'd1000)
        else $error("low-voltage reset active too early");
    a_lvr_rise:
    assert property (lowVoltageResetEnable && onCnt_ff >= 12'd1000 |-> lowVoltageResetActive)
        else $error("low-voltage reset not active after settling");
    a_rsvd_zero:
    assert property (read && !waitrequest && address == 9'h00c |-> (readdata & ~IMPL) == 0)
        else $error("reserved reset bits read nonzero");
    a_out_gated:
    assert property (read && !waitrequest && address == 9'h018 && !detectorEnable
        |-> readdata[6] == 1'b0 && readdata[31:8] == 24'h0) else $error("output bit not gated");
endmodule

bind periph_reset_and_brownout_ctrl prbc_chk_sva u_chk (.clk_sys, .rst, .address, .read,
    .write, .writedata, .byteenable, .readdata, .waitrequest, .detectorRaw, .periphRstMain,
    .periphRstSmartcard, .detectorEnable, .detectorThresholdSel, .detectorLowPowerSel,
    .lowVoltageResetEnable, .lowVoltageResetActive, .chipResetReq);

/* File: test/tb.sv */
// self-checking bench for the reset and brown-out control slice
// assumes the design under hdl and the bound port checker
`timescale 1ns/1ps
module tb;
    import prbc_pkg::*;
    localparam logic [31:0] IMPL = 32'h3bf7_f33e;
    logic           clk_sys = 1'b0;
    logic           rst = 1'b1;
    logic [8:0]     address = 9'h000;
    logic           read = 1'b0;
    logic           write = 1'b0;
    logic [31:0]    writedata = 32'h0;
    logic [3:0]     byteenable = 4'hf;
    logic [31:0]    flashUserConfigWord = 32'h00d0_0000;
    logic           detectorRaw = 1'b0;
    logic [31:0]    readdata, periphRstMain;
    logic [2:0]     periphRstSmartcard;
    thr_t           detectorThresholdSel;
    logic           waitrequest, detectorEnable, detectorLowPowerSel, irq;
    logic           lowVoltageResetEnable, lowVoltageResetActive, chipResetReq;
    int             miscompares = 0;
    int             checkCount = 0;
    periph_reset_and_brownout_ctrl dut (.clk_sys, .rst, .address, .read, .write, .writedata,
        .byteenable, .readdata, .waitrequest, .flashUserConfigWord, .detectorRaw,
        .periphRstMain, .periphRstSmartcard, .detectorEnable, .detectorThresholdSel,
        .detectorLowPowerSel, .lowVoltageResetEnable, .lowVoltageResetActive,
        .chipResetReq, .irq);
    // 10 MHz system clock
    always #50 clk_sys = ~clk_sys;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one bus cycle, held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk_sys);
        read <= !w;
        write <= w;
        address <= a;
        writedata <= d;
        do begin
            @(posedge clk_sys);
        end while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [8:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    task automatic unlock;
        wr(9'h100, 32'h0); // relock first: a key written while open relocks
        wr(9'h100, 32'h59);
        wr(9'h100, 32'h16);
        wr(9'h100, 32'h88);
    endtask
    task automatic t_reset;
        repeat (1000) @(posedge clk_sys);
        chk(32'(lowVoltageResetActive), 32'h0);
        repeat (1) @(posedge clk_sys);
        chk(32'(lowVoltageResetActive), 32'h1);
        rdc(9'h00c, 32'h0);
        rdc(9'h010, 32'h0);
        rdc(9'h018, 32'h8d);
        chk(32'(detectorThresholdSel), 32'h2);
        $display("reset test done");
    endtask
    task automatic t_periph;
        for (int i = 0; i < 32; i++) begin
            wr(9'h00c, 32'h1 << i);
            rdc(9'h00c, (32'h1 << i) & IMPL);
            chk(periphRstMain, (32'h1 << i) & IMPL);
        end
        wr(9'h00c, 32'h0);
        rdc(9'h00c, 32'h0);
        wr(9'h010, 32'hffff_ffff);
        rdc(9'h010, 32'h7);
        chk(32'(periphRstSmartcard), 32'h7);
        wr(9'h010, 32'h0);
        $display("periph test done");
    endtask
    task automatic t_protect;
        wr(9'h018, 32'h26);
        rdc(9'h018, 32'h8d);
        wr(9'h100, 32'h59);
        wr(9'h100, 32'h17);
        wr(9'h018, 32'h26);
        rdc(9'h018, 32'h8d);
        for (int t = 0; t < 4; t++) begin
            unlock;
            rdc(9'h100, 32'h1);
            wr(9'h018, 32'h81 | (t << 1));
            rdc(9'h018, 32'h81 | (t << 1));
            chk(32'(detectorThresholdSel), 32'(t));
        end
        wr(9'h018, 32'h20);
        rdc(9'h018, 32'h20);
        chk(32'(detectorLowPowerSel), 32'h1);
        chk(32'(lowVoltageResetEnable), 32'h0);
        wr(9'h100, 32'h0);
        rdc(9'h100, 32'h0);
        $display("protect test done");
    endtask
    task automatic t_detect;
        unlock;
        wr(9'h018, 32'h81);
        wr(9'h100, 32'h0);
        wr(9'h024, 32'h1);
        detectorRaw <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rdc(9'h018, 32'hd1);
        chk(32'(irq), 32'h1);
        chk(32'(chipResetReq), 32'h0);
        wr(9'h018, 32'h10);
        rdc(9'h018, 32'hc1);
        wr(9'h020, 32'h1);
        rdc(9'h020, 32'h2);
        chk(32'(irq), 32'h0);
        wr(9'h024, 32'h2);
        detectorRaw <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rdc(9'h018, 32'h91);
        wr(9'h018, 32'h0);
        rdc(9'h018, 32'h91);
        chk(32'(irq), 32'h1);
        unlock;
        wr(9'h018, 32'h80);
        rdc(9'h020, 32'h1);
        chk(32'(irq), 32'h0);
        $display("detect test done");
    endtask
    task automatic t_chip;
        unlock;
        wr(9'h018, 32'h89);
        detectorRaw <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk(32'(chipResetReq), 32'h1);
        unlock;
        wr(9'h018, 32'h88);
        rdc(9'h018, 32'h98);
        chk(32'(chipResetReq), 32'h0);
        detectorRaw <= 1'b0;
        $display("chip test done");
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checkCount, miscompares);
        if (miscompares == 0 && checkCount > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset;
        t_periph;
        t_protect;
        t_detect;
        t_chip;
        end_of_test;
    end
    // watchdog well past the expected run length
    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        end_of_test;
    end
endmodule
